// *** rtl/dac_channel_readback_decoder.sv ***
// Purpose: decode a read-back command and return one channel code as two bytes
// Assumes: command and access nibbles and the request strobe are synchronous
// Notes:   serial framing lives outside; this block only answers the strobe
`timescale 1ns/1ns

module dac_channel_readback_decoder
  import readback_pkg::*;
#(
  parameter int unsigned CH = NUM_CH
) (
  // clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   reset_i,
  // command side
  input  wire logic                   req_i,
  input  wire logic [NIBBLE_W-1:0]    command_nibble_i,
  input  wire logic [NIBBLE_W-1:0]    access_nibble_i,
  // channel register contents
  input  wire logic [CH*CODE_W-1:0]   input_buffer_i,
  input  wire logic [CH*CODE_W-1:0]   active_output_i,
  // answer side
  output logic                        valid_o,
  output logic                        invalid_o,
  output logic [BYTE_W-1:0]           msb_byte_o,
  output logic [BYTE_W-1:0]           lsb_byte_o
);

  // what a taken request turns into; anything refused is ANS_NONE
  typedef enum logic [1:0] {
    ANS_NONE,
    ANS_INPUT,
    ANS_OUTPUT,
    ANS_BAD
  } answer_kind_t;

  // the channel field is the access nibble below its invalid bit
  localparam int unsigned       CH_SEL_W  = ACC_INVALID_BIT;
  // reset values of the two answer bytes
  localparam logic [BYTE_W-1:0] MSB_RESET = CODE_RESET[HI_BYTE_MSB:HI_BYTE_LSB];
  localparam logic [BYTE_W-1:0] LSB_RESET = UNDEF_BYTE;

  // answer strobe
  logic                valid_ff;
  logic                nxt_valid;

  // answer payload, held until the next taken request
  logic                invalid_ff;
  logic                nxt_invalid;
  logic [BYTE_W-1:0]   msb_ff;
  logic [BYTE_W-1:0]   nxt_msb;
  logic [BYTE_W-1:0]   lsb_ff;
  logic [BYTE_W-1:0]   nxt_lsb;

  // decode
  logic                take;
  answer_kind_t        kind;
  logic [CH_SEL_W-1:0] ch_sel;
  logic [CODE_W-1:0]   in_code;
  logic [CODE_W-1:0]   out_code;
  logic [CODE_W-1:0]   in_bank  [CH];
  logic [CODE_W-1:0]   out_bank [CH];

  function automatic logic is_read_cmd(
    input logic [NIBBLE_W-1:0] cmd
  );
    is_read_cmd = (cmd == CMD_RD_INPUT) || (cmd == CMD_RD_OUTPUT);
  endfunction : is_read_cmd

  function automatic logic is_bad_access(
    input logic [NIBBLE_W-1:0] acc
  );
    is_bad_access = acc[ACC_INVALID_BIT];
  endfunction : is_bad_access

  function automatic logic [CH_SEL_W-1:0] channel_of(
    input logic [NIBBLE_W-1:0] acc
  );
    channel_of = acc[CH_SEL_W-1:0];
  endfunction : channel_of

  function automatic logic [BYTE_W-1:0] hi_byte(
    input logic [CODE_W-1:0] code
  );
    hi_byte = code[HI_BYTE_MSB:HI_BYTE_LSB];
  endfunction : hi_byte

  // the spare low nibble is a fixed value so the byte never carries noise
  function automatic logic [BYTE_W-1:0] lo_byte(
    input logic [CODE_W-1:0] code
  );
    lo_byte = {code[LO_NIB_MSB:LO_NIB_LSB], DONT_CARE_FILL};
  endfunction : lo_byte

  function automatic answer_kind_t classify(
    input logic                take_now,
    input logic [NIBBLE_W-1:0] cmd,
    input logic [NIBBLE_W-1:0] acc
  );
    if (!take_now) begin
      classify = ANS_NONE;
    end else if (is_bad_access(acc)) begin
      classify = ANS_BAD;
    end else if (cmd == CMD_RD_OUTPUT) begin
      classify = ANS_OUTPUT;
    end else begin
      classify = ANS_INPUT;
    end
  endfunction : classify

  // split the flat buses into channel arrays, A at index 0 up to H at index 7
  always_comb begin
    for (int n = 0; n < CH; n++) begin
      in_bank[n]  = input_buffer_i[n*CODE_W +: CODE_W];
      out_bank[n] = active_output_i[n*CODE_W +: CODE_W];
    end
  end

  // only the two channel read-back commands are taken; every other command is ignored
  always_comb begin
    take   = req_i && is_read_cmd(command_nibble_i);
    kind   = classify(take, command_nibble_i, access_nibble_i);
    ch_sel = channel_of(access_nibble_i);
  end

  // a channel number of CH or more reads as the reset code instead of an unknown
  always_comb begin
    in_code = CODE_RESET;
    if (ch_sel < CH) begin
      in_code = in_bank[ch_sel];
    end
  end

  always_comb begin
    out_code = CODE_RESET;
    if (ch_sel < CH) begin
      out_code = out_bank[ch_sel];
    end
  end

  // strobe group: one pulse per taken request; back-to-back requests give back-to-back pulses
  always_comb begin
    nxt_valid = 1'h0;
    unique case (kind)
      ANS_INPUT,
      ANS_OUTPUT,
      ANS_BAD: begin
        nxt_valid = 1'h1;
      end
      ANS_NONE: begin
        nxt_valid = 1'h0;
      end
    endcase
  end

  // async reset clears the answer at once; a request may follow the first edge after release
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      valid_ff <= 1'h0;
    end else begin
      valid_ff <= nxt_valid;
    end
  end

  // payload group: a refused command leaves the last answer standing
  always_comb begin
    nxt_invalid = invalid_ff;
    nxt_msb     = msb_ff;
    nxt_lsb     = lsb_ff;
    unique case (kind)
      ANS_INPUT: begin
        nxt_invalid = 1'h0;
        nxt_msb     = hi_byte(in_code);
        nxt_lsb     = lo_byte(in_code);
      end
      ANS_OUTPUT: begin
        nxt_invalid = 1'h0;
        nxt_msb     = hi_byte(out_code);
        nxt_lsb     = lo_byte(out_code);
      end
      ANS_BAD: begin
        // undefined data: a fixed pattern, so nothing leaks from another channel
        nxt_invalid = 1'h1;
        nxt_msb     = UNDEF_BYTE;
        nxt_lsb     = UNDEF_BYTE;
      end
      ANS_NONE: begin
        nxt_invalid = invalid_ff;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      invalid_ff <= 1'h0;
      msb_ff     <= MSB_RESET;
      lsb_ff     <= LSB_RESET;
    end else begin
      invalid_ff <= nxt_invalid;
      msb_ff     <= nxt_msb;
      lsb_ff     <= nxt_lsb;
    end
  end

  // outputs come straight from flip-flops
  assign valid_o    = valid_ff;
  assign invalid_o  = invalid_ff;
  assign msb_byte_o = msb_ff;
  assign lsb_byte_o = lsb_ff;

endmodule : dac_channel_readback_decoder

// *** pkg/readback_pkg.sv ***
// Purpose: constants for the channel read-back command decoder
// Assumes: 12-bit codes, eight channels, 4-bit command and access nibbles
// Notes:   command codes and byte field positions shared by design and bench
package readback_pkg;
  localparam int unsigned CODE_W      = 12;
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned NIBBLE_W    = 4;
  localparam int unsigned BYTE_W      = 8;
  localparam logic [3:0]  CMD_RD_INPUT  = 4'h0;
  localparam logic [3:0]  CMD_RD_OUTPUT = 4'h1;
  localparam int unsigned ACC_INVALID_BIT = 3;
  localparam int unsigned HI_BYTE_MSB = 11;
  localparam int unsigned HI_BYTE_LSB = 4;
  localparam int unsigned LO_NIB_MSB  = 3;
  localparam int unsigned LO_NIB_LSB  = 0;
  localparam logic [3:0]  DONT_CARE_FILL = 4'h0;
  localparam logic [7:0]  UNDEF_BYTE  = 8'h00;
  localparam logic [11:0] CODE_RESET  = 12'h000;
endpackage : readback_pkg

// *** testbench/readback_props.sv ***
// Purpose: answer checks for the channel read-back decoder
// Assumes: one clock, asynchronous active-high reset
// Notes:   sees only the decoder's ports; expected codes come from the bank inputs
`timescale 1ns/1ns
module readback_props (
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        reset_i,
  // command side
  input wire logic        req_i,
  input wire logic [3:0]  command_nibble_i,
  input wire logic [3:0]  access_nibble_i,
  // channel codes
  input wire logic [95:0] input_buffer_i,
  input wire logic [95:0] active_output_i,
  // answer side
  input wire logic        valid_o,
  input wire logic        invalid_o,
  input wire logic [7:0]  msb_byte_o,
  input wire logic [7:0]  lsb_byte_o
);
  logic [11:0] sel_code;
  assign sel_code = command_nibble_i[0] ? active_output_i[access_nibble_i[2:0]*12 +: 12]
                                        : input_buffer_i[access_nibble_i[2:0]*12 +: 12];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (reset_i);
  sequence take; req_i && command_nibble_i[3:1] == 3'h0; endsequence
  sequence good_take; take ##0 !access_nibble_i[3]; endsequence
  sequence bad_take; take ##0 access_nibble_i[3]; endsequence
  a_take_answer: assert property (take |=> valid_o) else $error("no answer");
  a_bad_access: assert property (bad_take |=> invalid_o && msb_byte_o == 8'h00)
    else $error("no flag");
  a_good_access: assert property (good_take |=> !invalid_o) else $error("flag");
  a_high_byte: assert property (good_take |=> msb_byte_o == $past(sel_code[11:4]))
    else $error("high byte");
  a_code_nibble: assert property (good_take |=> lsb_byte_o[7:4] == $past(sel_code[3:0]))
    else $error("code nibble");
  a_low_nibble: assert property (valid_o |-> lsb_byte_o[3:0] == 4'h0) else $error("low");
  a_no_stray: assert property (!take |=> !valid_o) else $error("stray");
  a_held_bytes: assert property (!take |=> $stable(msb_byte_o) && $stable(lsb_byte_o))
    else $error("bytes moved");
endmodule : readback_props
bind dac_channel_readback_decoder readback_props i_props (
  .core_clk_i       (core_clk_i),
  .reset_i          (reset_i),
  .req_i            (req_i),
  .command_nibble_i (command_nibble_i),
  .access_nibble_i  (access_nibble_i),
  .input_buffer_i   (input_buffer_i),
  .active_output_i  (active_output_i),
  .valid_o          (valid_o),
  .invalid_o        (invalid_o),
  .msb_byte_o       (msb_byte_o),
  .lsb_byte_o       (lsb_byte_o)
);

// *** testbench/chan_regs_model.sv ***
// Purpose: channel codes; Assumes: static; Notes: codes of neighbouring channels differ in every nibble
`timescale 1ns/1ns
module chan_regs_model import readback_pkg::*; (output logic [95:0] ib_o, ao_o);
  always_comb for (int n = 0; n < 8; n++) begin
    ib_o[n*12 +: 12] = 12'h1A5 + 12'(n * 'h2C3);
    ao_o[n*12 +: 12] = 12'hE3C - 12'(n * 'h1D7);
  end
endmodule : chan_regs_model

// *** testbench/tb_top.sv ***
// Purpose: bench for the channel read-back decoder
// Assumes: the answer stands 1 ns after the taking edge
// Notes:   table rows first, then hold, refused, back-to-back and mid-run reset cases
`timescale 1ns/1ns
module tb_top import readback_pkg::*;;
  logic        c = 1'h0;
  logic        r = 1'h1;
  logic        q = 1'h0;
  logic [3:0]  m = 4'h0;
  logic [3:0]  a = 4'h0;
  logic [95:0] ib;
  logic [95:0] ao;
  wire  [17:0] y;
  // row: {command, access, valid, invalid, msb byte, lsb byte}
  logic [25:0] rows [18];
  int          fails = 0;
  int          checks = 0;
  always #4 c = ~c;
  chan_regs_model i_chan_regs_model (.ib_o(ib), .ao_o(ao));
  dac_channel_readback_decoder i_dac_channel_readback_decoder (.core_clk_i(c), .reset_i(r),
    .req_i(q), .command_nibble_i(m), .access_nibble_i(a), .input_buffer_i(ib),
    .active_output_i(ao), .valid_o(y[17]), .invalid_o(y[16]), .msb_byte_o(y[15:8]),
    .lsb_byte_o(y[7:0]));
  task chk(input logic [17:0] e);
    checks++;
    if (y !== e) begin
      fails++;
      $display("BAD %0t %h %h", $time, y, e);
    end
  endtask : chk
  task finish_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task ask(input logic [3:0] cm, ac);
    @(posedge c);
    {q, m, a} <= {1'h1, cm, ac};
    @(posedge c);
    q <= 1'h0;
    #1;
  endtask : ask
  initial begin
    rows[0]  = {4'h0, 4'h8, 2'h3, 8'h00, 8'h00};
    rows[1]  = {4'h0, 4'h7, 2'h2, 8'h4F, 8'hA0};
    rows[2]  = {4'h0, 4'h6, 2'h2, 8'h23, 8'h70};
    rows[3]  = {4'h0, 4'h5, 2'h2, 8'hF7, 8'h40};
    rows[4]  = {4'h0, 4'h4, 2'h2, 8'hCB, 8'h10};
    rows[5]  = {4'h0, 4'h3, 2'h2, 8'h9E, 8'hE0};
    rows[6]  = {4'h0, 4'h2, 2'h2, 8'h72, 8'hB0};
    rows[7]  = {4'h0, 4'h1, 2'h2, 8'h46, 8'h80};
    rows[8]  = {4'h0, 4'h0, 2'h2, 8'h1A, 8'h50};
    rows[9]  = {4'h1, 4'hF, 2'h3, 8'h00, 8'h00};
    rows[10] = {4'h1, 4'h7, 2'h2, 8'h15, 8'hB0};
    rows[11] = {4'h1, 4'h6, 2'h2, 8'h33, 8'h20};
    rows[12] = {4'h1, 4'h5, 2'h2, 8'h50, 8'h90};
    rows[13] = {4'h1, 4'h4, 2'h2, 8'h6E, 8'h00};
    rows[14] = {4'h1, 4'h3, 2'h2, 8'h8B, 8'h70};
    rows[15] = {4'h1, 4'h2, 2'h2, 8'hA8, 8'hE0};
    rows[16] = {4'h1, 4'h1, 2'h2, 8'hC6, 8'h50};
    rows[17] = {4'h1, 4'h0, 2'h2, 8'hE3, 8'hC0};
    repeat (2) @(posedge c);
    r <= 1'h0;
    #1 chk(18'h0);
    for (int i = 0; i < 18; i++) begin
      ask(rows[i][25:22], rows[i][21:18]);
      chk(rows[i][17:0]);
    end
    // strobe drops after one cycle, bytes stand
    @(posedge c);
    #1 chk(18'h0E3C0);
    // other command with the top access bit: ignored, no flag
    ask(4'h2, 4'h8);
    chk(18'h0E3C0);
    // back to back: input read, invalid read, output read
    @(posedge c);
    {q, m, a} <= {1'h1, 4'h0, 4'h3};
    @(posedge c);
    {m, a} <= {4'h1, 4'hD};
    #1 chk(18'h29EE0);
    @(posedge c);
    {m, a} <= {4'h1, 4'h5};
    #1 chk(18'h30000);
    @(posedge c);
    q <= 1'h0;
    #1 chk(18'h25090);
    // reset in mid-run clears a standing answer
    @(posedge c);
    r <= 1'h1;
    #1 chk(18'h0);
    @(posedge c);
    r <= 1'h0;
    ask(4'h0, 4'h6);
    chk(18'h22370);
    finish_test();
  end
endmodule : tb_top
